// ===== bench/fpc_array_model.sv
`timescale 1ns/1ns
`default_nettype none
module fpc_array_model (
    input  wire logic       sys_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       flash_start_i,
    input  wire logic [7:0] delay_i,
    output logic            flash_done_o
);
    logic [7:0] cnt_reg;
    logic       run_reg;
    // Delay is taken at start so the bench can run prompt and slow operations
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_reg      <= 8'h00;
            run_reg      <= 1'b0;
            flash_done_o <= 1'b0;
        end else begin
            flash_done_o <= run_reg && (cnt_reg == 8'h00) && !flash_start_i;
            if (flash_start_i) begin
                run_reg <= 1'b1;
                cnt_reg <= delay_i;
            end else if (run_reg && (cnt_reg == 8'h00)) begin
                run_reg <= 1'b0;
            end else if (run_reg) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end
endmodule : fpc_array_model
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        sys_clk_i   = 1'b0;
    logic        nrst_i      = 1'b0;
    logic        sfr_wr_i    = 1'b0;
    logic [7:0]  sfr_addr_i  = 8'h00;
    logic [7:0]  sfr_wdata_i = 8'h00;
    logic        instr_i     = 1'b0;
    logic        exec_boot_i = 1'b1;
    logic        xwr_i       = 1'b0;
    logic [15:0] xwr_addr_i  = 16'h0000;
    logic [7:0]  xwr_data_i  = 8'h00;
    logic        ext_sel     = 1'b0;
    logic [6:0]  lat_addr    = 7'h00;
    logic [7:0]  delay       = 8'h28;
    logic [2:0]  fuse        = 3'h3;
    logic [7:0]  sfr_rdata_o, flash_page_o, lat_data;
    logic [2:0]  code_space_o, fetch_bank_o, flash_op_o;
    logic [1:0]  op_bank_o, flash_bank_o;
    logic        xdata_wr_o, xdata_ext_o, flash_start_o, done, programming_busy_o;
    int          mismatches = 0;
    int          n_tests    = 0;

    always #10 sys_clk_i = ~sys_clk_i;

    fpc_flash_program_control uut (
        .sys_clk_i, .nrst_i, .sfr_wr_i, .sfr_addr_i, .sfr_wdata_i, .sfr_rdata_o, .instr_i, .exec_boot_i,
        .boot_vector_fuse_i(fuse), .xwr_i, .xwr_addr_i, .xwr_data_i, .external_ram_select_i(ext_sel),
        .xdata_wr_o, .xdata_ext_o, .code_space_o, .fetch_bank_o, .op_bank_o, .flash_start_o, .flash_op_o,
        .flash_page_o, .flash_bank_o, .flash_done_i(done), .flash_lat_addr_i(lat_addr),
        .flash_lat_data_o(lat_data), .programming_busy_o
    );

    fpc_array_model partner (
        .sys_clk_i, .nrst_i, .flash_start_i(flash_start_o), .delay_i(delay), .flash_done_o(done)
    );

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        #2;
        sfr_wr_i    = 1'b1;
        sfr_addr_i  = a;
        sfr_wdata_i = d;
        instr_i     = 1'b1;
        @(posedge sys_clk_i);
        #2;
        sfr_wr_i = 1'b0;
        instr_i  = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        #2;
        sfr_addr_i = a;
        @(posedge sys_clk_i);
        #2;
        check("register", sfr_rdata_o, exp);
    endtask : rd

    task automatic xw(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        #2;
        xwr_i      = 1'b1;
        xwr_addr_i = a;
        xwr_data_i = d;
        instr_i    = 1'b1;
        #1;
        check("xdata_wr", xdata_wr_o, 1'b0);
        @(posedge sys_clk_i);
        #2;
        xwr_i   = 1'b0;
        instr_i = 1'b0;
    endtask : xw

    task automatic lat(input logic [6:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        #2;
        lat_addr = a;
        repeat (2) @(posedge sys_clk_i);
        #2;
        check("latch", lat_data, exp);
    endtask : lat

    // Keys go out on consecutive instructions, latch map kept on
    task automatic launch(input logic [2:0] t, input logic exp_start);
        logic seen;
        seen = 1'b0;
        @(posedge sys_clk_i);
        #2;
        sfr_wr_i    = 1'b1;
        sfr_addr_i  = 8'hd1;
        sfr_wdata_i = {4'h5, 1'b1, t};
        instr_i     = 1'b1;
        @(posedge sys_clk_i);
        #2;
        sfr_wdata_i = {4'ha, 1'b1, t};
        @(posedge sys_clk_i);
        #2;
        sfr_wr_i = 1'b0;
        instr_i  = 1'b0;
        repeat (6) begin
            @(posedge sys_clk_i);
            #2;
            if (flash_start_o === 1'b1) begin
                seen = 1'b1;
                check("op", flash_op_o, t);
            end
        end
        check("start", seen, exp_start);
    endtask : launch

    task automatic wait_idle;
        int i;
        for (i = 0; i < 300; i++) begin
            @(posedge sys_clk_i);
            #2;
            if (programming_busy_o === 1'b0) break;
        end
        if (i == 300) begin
            mismatches++;
            report_and_stop();
        end
    endtask : wait_idle

    task automatic t_reset;
        check("fetch", fetch_bank_o, 3'h4);
        rd(8'h92, 8'h04);
        rd(8'hd1, 8'h00);
        rd(8'hd3, 8'h80);
    endtask : t_reset

    task automatic t_bank;
        wr(8'h92, 8'hff);
        rd(8'h92, 8'he7);
        check("op_bank", op_bank_o, 2'h3);
        wr(8'h92, 8'h01);
        rd(8'h92, 8'h05);
        check("op_bank", op_bank_o, 2'h1);
    endtask : t_bank

    task automatic t_route;
        ext_sel = 1'b1;
        wr(8'hd1, 8'h08);
        check("xdata_ext", xdata_ext_o, 1'b0);
        xw(16'h0002, 8'h77);
        rd(8'hd3, 8'h82);
        wr(8'hd1, 8'h00);
        xwr_i = 1'b1;
        #1;
        check("xdata_wr", xdata_wr_o, 1'b1);
        check("xdata_ext", xdata_ext_o, 1'b1);
        @(posedge sys_clk_i);
        #2;
        xwr_i   = 1'b0;
        ext_sel = 1'b0;
        launch(3'h3, 1'b0);
        wait_idle();
        rd(8'hd3, 8'h80);
    endtask : t_route

    task automatic t_seq_err;
        launch(3'h0, 1'b0);
        rd(8'hd3, 8'h84);
        wr(8'hd3, 8'h80);
        rd(8'hd3, 8'h80);
        // Key 5, then a plain instruction, then key A
        @(posedge sys_clk_i);
        #2;
        sfr_wr_i    = 1'b1;
        sfr_addr_i  = 8'hd1;
        sfr_wdata_i = 8'h58;
        instr_i     = 1'b1;
        @(posedge sys_clk_i);
        #2;
        sfr_wr_i = 1'b0;
        @(posedge sys_clk_i);
        #2;
        sfr_wr_i    = 1'b1;
        sfr_wdata_i = 8'ha8;
        @(posedge sys_clk_i);
        #2;
        sfr_wr_i = 1'b0;
        instr_i  = 1'b0;
        rd(8'hd3, 8'h84);
    endtask : t_seq_err

    task automatic t_program;
        xw(16'h4085, 8'h3c);
        rd(8'hd3, 8'h86);
        check("page", flash_page_o, 8'h81);
        check("bank", flash_bank_o, 2'h1);
        lat(7'h05, 8'h3c);
        lat(7'h06, 8'hff);
        launch(3'h0, 1'b1);
        rd(8'hd3, 8'h81);
        xw(16'h4085, 8'h11);
        wr(8'hd3, 8'h80);
        rd(8'hd3, 8'h81);
        lat(7'h05, 8'h3c);
        wait_idle();
        rd(8'hd3, 8'h80);
    endtask : t_program

    task automatic t_targets;
        logic [2:0] tl [5];
        tl = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h3};
        delay = 8'h01;
        foreach (tl[k]) begin
            xw(16'h0003, 8'h20);
            launch(tl[k], tl[k] != 3'h3);
            wait_idle();
            rd(8'hd3, 8'h80);
        end
        lat(7'h03, 8'hff);
    endtask : t_targets

    task automatic t_reserved;
        xw(16'h0010, 8'h5a);
        launch(3'h6, 1'b0);
        launch(3'h7, 1'b0);
        rd(8'hd3, 8'h82);
        lat(7'h10, 8'h5a);
        launch(3'h3, 1'b0);
        wait_idle();
    endtask : t_reserved

    task automatic t_code;
        wr(8'hd1, 8'h01);
        check("space", code_space_o, 3'h2);
        wr(8'hd1, 8'h04);
        check("space", code_space_o, 3'h3);
        wr(8'hd1, 8'h05);
        check("space", code_space_o, 3'h4);
        wr(8'hd1, 8'h00);
        check("space", code_space_o, 3'h1);
        wr(8'hd3, 8'h00);
        check("space", code_space_o, 3'h0);
        exec_boot_i = 1'b0;
        wr(8'hd3, 8'h80);
        rd(8'hd3, 8'h00);
        check("space", code_space_o, 3'h0);
    endtask : t_code

    // Second reset with a user-flash fuse code
    task automatic t_fuse;
        fuse   = 3'h5;
        nrst_i = 1'b0;
        repeat (2) @(posedge sys_clk_i);
        #2;
        nrst_i = 1'b1;
        repeat (2) @(posedge sys_clk_i);
        #2;
        check("fetch", fetch_bank_o, 3'h1);
        rd(8'hd3, 8'h00);
        rd(8'h92, 8'h01);
    endtask : t_fuse

    initial begin
        repeat (6) @(posedge sys_clk_i);
        #2;
        nrst_i = 1'b1;
        repeat (2) @(posedge sys_clk_i);
        #2;
        t_reset();
        t_bank();
        t_route();
        t_seq_err();
        t_program();
        t_targets();
        t_reserved();
        t_code();
        t_fuse();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire

// ===== common/fpc_pkg.sv
package fpc_pkg;
    localparam logic [7:0] BANK_SELECT_ADDR   = 8'h92;
    localparam logic [7:0] FLASH_CONTROL_ADDR = 8'hd1;
    localparam logic [7:0] FLASH_STATUS_ADDR  = 8'hd3;
    localparam logic [7:0] FLASH_CONTROL_RST  = 8'h00;
    localparam logic [2:0] BANK_OVERRIDE_RST  = 3'h0;
    localparam int         MBO_LSB            = 5;
    localparam int         KEY_LSB            = 4;
    localparam int         LATCH_MAP_BIT      = 3;
    localparam int         REDIRECT_BIT       = 7;
    localparam int         SEQ_ERR_BIT        = 2;
    localparam int         LOADED_BIT         = 1;
    localparam int         BUSY_BIT           = 0;
    localparam int         OFFSET_LSB         = 0;
    localparam int         PAGE_LSB           = 7;
    localparam int         PAGE_MSB           = 14;
    localparam logic [3:0] KEY_FIRST          = 4'h5;
    localparam logic [3:0] KEY_SECOND         = 4'ha;
    localparam logic [2:0] BRV_BOOT           = 3'h3;
    localparam logic [2:0] BRV_BANK0_TOP      = 3'h6;
    localparam logic [2:0] BRV_BANK1_TOP      = 3'h5;
    localparam logic [2:0] BRV_BANK2_TOP      = 3'h4;
    localparam logic [2:0] FETCH_BANK0        = 3'h0;
    localparam logic [2:0] FETCH_BANK1        = 3'h1;
    localparam logic [2:0] FETCH_BANK2        = 3'h2;
    localparam logic [2:0] FETCH_BOOT         = 3'h4;
    localparam logic [7:0] ERASED_BYTE        = 8'hff;
    typedef enum logic [2:0] {
        TS_USER = 3'h0, TS_EXTRA = 3'h1, TS_ERASE = 3'h2, TS_LATCH_RST = 3'h3,
        TS_SECURITY = 3'h4, TS_FUSE = 3'h5, TS_RSVD_A = 3'h6, TS_RSVD_B = 3'h7
    } fpc_target_t;
    typedef enum logic [2:0] {
        CS_USER = 3'h0, CS_BOOT = 3'h1, CS_EXTRA = 3'h2, CS_SECURITY = 3'h3, CS_FUSE = 3'h4
    } fpc_code_space_t;
    typedef enum logic [1:0] {
        KS_IDLE = 2'b00, KS_ARMED = 2'b01
    } fpc_key_state_t;
endpackage : fpc_pkg

// ===== design/fpc_flash_program_control.sv
`timescale 1ns/1ns
`default_nettype none
module fpc_flash_program_control #(
    parameter int LATCH_DEPTH = 128,
    parameter int OFFSET_W    = 7
) (
    input  wire logic                sys_clk_i,
    input  wire logic                nrst_i,
    input  wire logic                sfr_wr_i,
    input  wire logic [7:0]          sfr_addr_i,
    input  wire logic [7:0]          sfr_wdata_i,
    output logic      [7:0]          sfr_rdata_o,
    input  wire logic                instr_i,
    input  wire logic                exec_boot_i,
    input  wire logic [2:0]          boot_vector_fuse_i,
    input  wire logic                xwr_i,
    input  wire logic [15:0]         xwr_addr_i,
    input  wire logic [7:0]          xwr_data_i,
    input  wire logic                external_ram_select_i,
    output logic                     xdata_wr_o,
    output logic                     xdata_ext_o,
    output logic [2:0]               code_space_o,
    output logic [2:0]               fetch_bank_o,
    output logic [1:0]               op_bank_o,
    output logic                     flash_start_o,
    output logic [2:0]               flash_op_o,
    output logic [7:0]               flash_page_o,
    output logic [1:0]               flash_bank_o,
    input  wire logic                flash_done_i,
    input  wire logic [OFFSET_W-1:0] flash_lat_addr_i,
    output logic      [7:0]          flash_lat_data_o,
    output logic                     programming_busy_o
);
    logic [2:0] mbo_reg, mbo_next;
    logic [2:0] fetch_reg, fetch_next;
    logic [7:0] flash_control_reg, flash_control_next;
    logic       redirect_reg, redirect_next;
    logic       seq_err_reg, seq_err_next;
    logic       loaded_reg, loaded_next;
    logic       busy_reg, busy_next;
    logic       boot_load_reg, boot_load_next;
    logic [7:0] page_reg, page_next;
    logic [1:0] bank_reg, bank_next;
    logic [2:0] op_reg, op_next;
    logic       start_reg, start_next;
    logic [7:0] rdata_next;
    logic [2:0] fuse_fetch;
    logic       wr_bank, wr_flash_control, wr_stat;
    logic       lat_wr, lat_clr;
    logic       key_launch, key_err;
    logic [2:0] tsel;
    logic       tsel_rsvd;

    assign tsel      = flash_control_reg[2:0];
    assign tsel_rsvd = (tsel == fpc_pkg::TS_RSVD_A) || (tsel == fpc_pkg::TS_RSVD_B);
    assign lat_wr    = xwr_i && flash_control_reg[fpc_pkg::LATCH_MAP_BIT] && !busy_reg;
    assign op_bank_o = mbo_reg[2] ? mbo_reg[1:0] : fetch_reg[1:0];

    always_comb begin
        wr_bank = 1'b0;
        wr_flash_control = 1'b0;
        wr_stat = 1'b0;
        if (sfr_wr_i && sfr_addr_i == fpc_pkg::BANK_SELECT_ADDR) begin
            wr_bank = 1'b1;
        end else if (sfr_wr_i && sfr_addr_i == fpc_pkg::FLASH_CONTROL_ADDR) begin
            wr_flash_control = 1'b1;
        end else if (sfr_wr_i && sfr_addr_i == fpc_pkg::FLASH_STATUS_ADDR) begin
            wr_stat = 1'b1;
        end
    end

    // Unused fuse codes boot like the plain user-flash start
    always_comb begin
        case (boot_vector_fuse_i)
            fpc_pkg::BRV_BOOT:      fuse_fetch = fpc_pkg::FETCH_BOOT;
            fpc_pkg::BRV_BANK1_TOP: fuse_fetch = fpc_pkg::FETCH_BANK1;
            fpc_pkg::BRV_BANK2_TOP: fuse_fetch = fpc_pkg::FETCH_BANK2;
            default:                fuse_fetch = fpc_pkg::FETCH_BANK0;
        endcase
    end

    fpc_key_seq u_key (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .flash_control_wr_i (wr_flash_control),
        .key_i     (sfr_wdata_i[fpc_pkg::KEY_LSB +: 4]),
        .instr_i   (instr_i),
        .launch_o  (key_launch),
        .err_o     (key_err)
    );

    always_comb begin
        mbo_next       = mbo_reg;
        fetch_next     = fetch_reg;
        flash_control_next      = flash_control_reg;
        redirect_next  = redirect_reg;
        seq_err_next   = seq_err_reg;
        loaded_next    = loaded_reg;
        busy_next      = busy_reg;
        boot_load_next = 1'b0;
        page_next      = page_reg;
        bank_next      = bank_reg;
        op_next        = op_reg;
        start_next     = 1'b0;
        lat_clr        = 1'b0;
        if (boot_load_reg) begin
            fetch_next    = fuse_fetch;
            redirect_next = (boot_vector_fuse_i == fpc_pkg::BRV_BOOT);
        end
        if (wr_bank) begin
            mbo_next        = sfr_wdata_i[fpc_pkg::MBO_LSB +: 3];
            fetch_next[1:0] = sfr_wdata_i[1:0];
        end
        if (wr_flash_control) begin
            flash_control_next = sfr_wdata_i;
        end
        if (wr_stat) begin
            if (exec_boot_i) begin
                redirect_next = sfr_wdata_i[fpc_pkg::REDIRECT_BIT];
            end
            if (!sfr_wdata_i[fpc_pkg::SEQ_ERR_BIT]) begin
                seq_err_next = 1'b0;
            end
        end
        if (flash_done_i) begin
            busy_next = 1'b0;
        end
        // Hardware setting of the error wins over the software clear above
        if (key_err) begin
            seq_err_next = 1'b1;
        end else if (key_launch && !busy_reg) begin
            if (tsel_rsvd) begin
                seq_err_next = 1'b0;
            end else if (!loaded_reg) begin
                seq_err_next = 1'b1;
            end else begin
                seq_err_next = 1'b0;
                loaded_next  = 1'b0;
                if (tsel == fpc_pkg::TS_LATCH_RST) begin
                    lat_clr = 1'b1;
                end else begin
                    start_next = 1'b1;
                    busy_next  = 1'b1;
                    op_next    = tsel;
                end
            end
        end
        // The last latch write fixes page and bank
        if (lat_wr) begin
            loaded_next = 1'b1;
            page_next   = xwr_addr_i[fpc_pkg::PAGE_MSB:fpc_pkg::PAGE_LSB];
            bank_next   = op_bank_o;
        end
    end

    always_comb begin
        rdata_next = 8'h00;
        if (sfr_addr_i == fpc_pkg::BANK_SELECT_ADDR) begin
            rdata_next = {mbo_reg, 2'b00, fetch_reg};
        end else if (sfr_addr_i == fpc_pkg::FLASH_CONTROL_ADDR) begin
            rdata_next = flash_control_reg;
        end else if (sfr_addr_i == fpc_pkg::FLASH_STATUS_ADDR) begin
            rdata_next = {redirect_reg, 4'h0, seq_err_reg, loaded_reg, busy_reg};
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mbo_reg       <= fpc_pkg::BANK_OVERRIDE_RST;
            fetch_reg     <= fpc_pkg::FETCH_BANK0;
            flash_control_reg      <= fpc_pkg::FLASH_CONTROL_RST;
            redirect_reg  <= 1'b0;
            seq_err_reg   <= 1'b0;
            loaded_reg    <= 1'b0;
            busy_reg      <= 1'b0;
            boot_load_reg <= 1'b1;
            page_reg      <= 8'h00;
            bank_reg      <= 2'h0;
            op_reg        <= 3'h0;
            start_reg     <= 1'b0;
            sfr_rdata_o   <= 8'h00;
        end else begin
            mbo_reg       <= mbo_next;
            fetch_reg     <= fetch_next;
            flash_control_reg      <= flash_control_next;
            redirect_reg  <= redirect_next;
            seq_err_reg   <= seq_err_next;
            loaded_reg    <= loaded_next;
            busy_reg      <= busy_next;
            boot_load_reg <= boot_load_next;
            page_reg      <= page_next;
            bank_reg      <= bank_next;
            op_reg        <= op_next;
            start_reg     <= start_next;
            sfr_rdata_o   <= rdata_next;
        end
    end

    fpc_latch_mem #(
        .DEPTH (LATCH_DEPTH),
        .AW    (OFFSET_W),
        .DW    (8)
    ) u_latch (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .wr_i      (lat_wr),
        .waddr_i   (xwr_addr_i[fpc_pkg::OFFSET_LSB +: OFFSET_W]),
        .wdata_i   (xwr_data_i),
        .clr_i     (lat_clr),
        .raddr_i   (flash_lat_addr_i),
        .rdata_o   (flash_lat_data_o)
    );

    // Latch map wins over the external RAM select bit
    assign xdata_wr_o  = xwr_i && !flash_control_reg[fpc_pkg::LATCH_MAP_BIT];
    assign xdata_ext_o = external_ram_select_i && !flash_control_reg[fpc_pkg::LATCH_MAP_BIT];

    always_comb begin
        case (tsel)
            fpc_pkg::TS_EXTRA:    code_space_o = fpc_pkg::CS_EXTRA;
            fpc_pkg::TS_SECURITY: code_space_o = fpc_pkg::CS_SECURITY;
            fpc_pkg::TS_FUSE:     code_space_o = fpc_pkg::CS_FUSE;
            default: code_space_o = (exec_boot_i && redirect_reg) ? fpc_pkg::CS_BOOT : fpc_pkg::CS_USER;
        endcase
    end

    assign fetch_bank_o       = fetch_reg;
    assign flash_start_o      = start_reg;
    assign flash_op_o         = op_reg;
    assign flash_page_o       = page_reg;
    assign flash_bank_o       = bank_reg;
    assign programming_busy_o = busy_reg;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_good_launch;
        key_launch && !key_err && !busy_reg && loaded_reg && !tsel_rsvd && tsel != fpc_pkg::TS_LATCH_RST;
    endsequence

    a_launch_busy: assert property (s_good_launch |=> busy_reg && start_reg && !loaded_reg && !seq_err_reg)
        else $error("good launch did not start");
    a_busy_hold: assert property (busy_reg && !flash_done_i |=> busy_reg)
        else $error("busy dropped before completion");
    a_latch_busy: assert property (busy_reg && xwr_i |=> $stable(page_reg))
        else $error("latch write taken while busy");
    a_empty_launch: assert property (key_launch && !busy_reg && !loaded_reg && !tsel_rsvd
                                     |=> seq_err_reg && !start_reg)
        else $error("empty launch not flagged");
    a_loaded_set: assert property (lat_wr |=> loaded_reg)
        else $error("latch write did not set loaded");
    a_redirect_guard: assert property (wr_stat && !exec_boot_i && !boot_load_reg |=> $stable(redirect_reg))
        else $error("redirect changed from user code");
    a_fetch_top: assert property (!boot_load_reg |=> $stable(fetch_reg[2]))
        else $error("fetch top bit changed");
    a_reserved_op: assert property (key_launch && tsel_rsvd |=> !start_reg && $stable(busy_reg))
        else $error("reserved target started operation");
endmodule : fpc_flash_program_control
`default_nettype wire

// ===== design/fpc_key_seq.sv
`timescale 1ns/1ns
`default_nettype none
module fpc_key_seq (
    input  wire logic       sys_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       flash_control_wr_i,
    input  wire logic [3:0] key_i,
    input  wire logic       instr_i,
    output logic            launch_o,
    output logic            err_o
);
    fpc_pkg::fpc_key_state_t state_reg;
    fpc_pkg::fpc_key_state_t state_next;
    logic                    launch_next;
    logic                    err_next;

    always_comb begin
        state_next  = state_reg;
        launch_next = 1'b0;
        err_next    = 1'b0;
        if (flash_control_wr_i && key_i == fpc_pkg::KEY_FIRST) begin
            state_next = fpc_pkg::KS_ARMED;
        end else if (flash_control_wr_i && key_i == fpc_pkg::KEY_SECOND) begin
            launch_next = (state_reg == fpc_pkg::KS_ARMED);
            err_next    = (state_reg != fpc_pkg::KS_ARMED);
            state_next  = fpc_pkg::KS_IDLE;
        end else if (state_reg == fpc_pkg::KS_ARMED && (instr_i || flash_control_wr_i)) begin
            // Any instruction between the two key writes breaks the pair, unless it rewrites the first key
            err_next   = 1'b1;
            state_next = fpc_pkg::KS_IDLE;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= fpc_pkg::KS_IDLE;
            launch_o  <= 1'b0;
            err_o     <= 1'b0;
        end else begin
            state_reg <= state_next;
            launch_o  <= launch_next;
            err_o     <= err_next;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_arm;
        flash_control_wr_i && key_i == fpc_pkg::KEY_FIRST;
    endsequence
    sequence s_fire;
        flash_control_wr_i && key_i == fpc_pkg::KEY_SECOND;
    endsequence

    a_key_pair: assert property (s_arm ##1 s_fire |=> launch_o && !err_o)
        else $error("key pair did not launch");
    a_key_gap: assert property (s_arm ##1 (instr_i && !flash_control_wr_i) ##1 s_fire |=> !launch_o && err_o)
        else $error("split key pair launched");
    a_lone_second: assert property ((s_fire and (state_reg == fpc_pkg::KS_IDLE)) |=> err_o && !launch_o)
        else $error("second key alone not flagged");
endmodule : fpc_key_seq
`default_nettype wire

// ===== design/fpc_latch_mem.sv
`timescale 1ns/1ns
`default_nettype none
module fpc_latch_mem #(
    parameter int DEPTH = 128,
    parameter int AW    = 7,
    parameter int DW    = 8
) (
    input  wire logic          sys_clk_i,
    input  wire logic          nrst_i,
    input  wire logic          wr_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic          clr_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [DW-1:0] rdata_o
);
    logic [DW-1:0]    mem [DEPTH];
    logic [DEPTH-1:0] mask_reg;
    logic [DEPTH-1:0] mask_next;
    logic [DW-1:0]    rdata_next;

    // A write in the clearing cycle survives the clear
    always_comb begin
        mask_next = clr_i ? '0 : mask_reg;
        if (wr_i) begin
            mask_next[waddr_i] = 1'b1;
        end
        rdata_next = mask_reg[raddr_i] ? mem[raddr_i] : fpc_pkg::ERASED_BYTE;
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mask_reg <= '0;
            rdata_o  <= fpc_pkg::ERASED_BYTE;
        end else begin
            mask_reg <= mask_next;
            rdata_o  <= rdata_next;
        end
    end

    // Array has no reset; the mask decides what is valid
    always_ff @(posedge sys_clk_i) begin
        if (wr_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_cleared;
        clr_i && !wr_i ##1 !wr_i;
    endsequence

    a_erased_fill: assert property (s_cleared |=> rdata_o == fpc_pkg::ERASED_BYTE)
        else $error("unloaded latch byte not erased value");
endmodule : fpc_latch_mem
`default_nettype wire
